// ===== logic/gdrv_regs.sv
`timescale 1ns/1ps
`include "gdrv_params.svh"
module gdrv_regs (
  input  wire logic       CLK_SYS,                // System clock
  input  wire logic       RESET,                  // Power-up reset, async
  input  wire logic       SPI_SCLK,               // Serial clock from master
  input  wire logic       SPI_CS_N,               // Frame select, low active
  input  wire logic       SPI_SDI,                // Serial data in
  output logic            SPI_SDO,                // Serial data out
  output logic            SPI_SDO_OE,             // Output enable of data out
  input  wire logic       SLEEP_ACTIVE,           // Device is in sleep
  input  wire logic       TEMP_105_FLAG,          // Near 105 C
  input  wire logic       TEMP_125_FLAG,          // Near 125 C
  input  wire logic       TEMP_135_FLAG,          // Near 135 C
  input  wire logic       TEMP_175_FLAG,          // Near 175 C
  input  wire logic       MAIN_SUPPLY_LOW_WARN,   // Supply under
  input  wire logic       MAIN_SUPPLY_HIGH_WARN,  // Supply over
  input  wire logic       PUMP_LOW_WARN,          // Pump under
  input  wire logic       OVERHEAT_WARNING,       // Overtemp warning
  input  wire logic [5:0] DRAIN_OC,               // AH,AL,BH,BL,CH,CL
  input  wire logic [2:0] SENSE_OC,               // C,B,A
  input  wire logic [2:0] SUPPLY_FAULTS,          // Lockout,watchdog,shutdown
  input  wire logic [2:0] REG_FAULTS,             // Regulator,analog,low-side
  input  wire logic [2:0] PUMP_FAULTS,            // Under,over,abs over
  input  wire logic [5:0] GATE_FAULT,             // AH,AL,BH,BL,CH,CL
  output logic [1:0]      HS_PEAK_DRIVE_TIME,     // Drive time code
  output logic [3:0]      HS_PEAK_SINK_CURRENT,   // Sink current code
  output logic [3:0]      HS_PEAK_SOURCE_CURRENT, // Source current code
  output logic            WD_SERVICE              // Watchdog service pulse
);

  // State of each clock domain
  gdrv_pkg::fall_state_t f_q;  // Frame progress
  gdrv_pkg::fall_state_t f_d;
  gdrv_pkg::hold_state_t h_q;  // Finished word
  gdrv_pkg::hold_state_t h_d;
  gdrv_pkg::rise_state_t r_q;  // Output bit
  gdrv_pkg::rise_state_t r_d;
  gdrv_pkg::sys_state_t  s_q;  // System side
  gdrv_pkg::sys_state_t  s_d;

  // Frame progress and output bit are cleared whenever select is high; the finished word is kept
  logic        link_rst;     // Frame reset
  logic [31:0] mon_raw;      // All monitor pins
  logic [10:0] warn_img;     // Warning word
  logic [10:0] oc_img;       // Overcurrent word
  logic [10:0] dev_img;      // Device fault word
  logic [10:0] gate_img;     // Gate fault word
  logic        any_fault;    // Any fault set
  logic        commit_any;   // Full frame ended
  logic        commit_ok;    // Full frame of exactly sixteen bits
  logic        commit_wr;    // Write to drive strength
  logic        commit_rd;    // Read of a status word
  logic        sleep_entry;  // First cycle of sleep
  logic [10:0] resp_data;    // Word being sent back
  logic [3:0]  resp_idx;     // Bit index into response

  assign link_rst = RESET | SPI_CS_N;

  // Gather monitors; all are async, synced below
  assign mon_raw = {TEMP_175_FLAG, MAIN_SUPPLY_LOW_WARN,
                    MAIN_SUPPLY_HIGH_WARN, PUMP_LOW_WARN,
                    TEMP_105_FLAG, TEMP_125_FLAG, TEMP_135_FLAG,
                    OVERHEAT_WARNING, DRAIN_OC, SENSE_OC,
                    SUPPLY_FAULTS, REG_FAULTS, PUMP_FAULTS, GATE_FAULT};

  // Status images from synced monitors
  assign oc_img   = {s_q.mon_s2[23:18], 2'h0,
                     s_q.mon_s2[17:15]};
  assign dev_img  = {s_q.mon_s2[14:12], 1'b0,
                     s_q.mon_s2[11:9], 1'b0,
                     s_q.mon_s2[8:6]};
  assign gate_img = {s_q.mon_s2[5:0], 5'h00};
  assign any_fault = (|oc_img) | (|dev_img) | (|gate_img);
  // Bit 9 reserved; bit 5 is left zero here and filled below
  assign warn_img = {any_fault, 1'b0,
                     s_q.mon_s2[31],
                     s_q.mon_s2[30:29],
                     1'b0,
                     s_q.mon_s2[28],
                     s_q.mon_s2[27:25],
                     s_q.mon_s2[24]};
  // Bit 5 is spliced in here from the drain monitors, unlatched
  logic [10:0] warn_full;  // Warning word with drain OR
  always_comb begin
    warn_full = warn_img;
    warn_full[`WARN_DRAIN_BIT] = |s_q.mon_s2[23:18];
  end

  // Frame commit decode on the system side
  assign commit_any = s_q.cs_s2 && (s_q.tog_s2 != s_q.tog_seen);
  assign commit_ok  = commit_any && !h_q.ovr;
  assign commit_wr  = commit_ok && !h_q.word[`RW_BIT] &&
                      (h_q.word[`ADDR_MSB:`ADDR_LSB] == `RA_HS);
  assign commit_rd  = commit_ok && h_q.word[`RW_BIT] &&
                      (h_q.word[`ADDR_MSB:`ADDR_LSB] >= `RA_WARN) &&
                      (h_q.word[`ADDR_MSB:`ADDR_LSB] <= `RA_GATE);
  assign sleep_entry = SLEEP_ACTIVE && !s_q.sleep_q;

  // Falling edge: capture one command bit per edge
  always_comb begin
    f_d = f_q;
    f_d.sh = {f_q.sh[14:0], SPI_SDI};
    if (f_q.cnt != `FRAME_OVER) begin
      f_d.cnt = f_q.cnt + 5'd1;
    end
    if (f_q.cnt == (`ADDR_FALLS - 5'd1)) begin           // Fifth bit in
      f_d.addr = {f_q.sh[2:0], SPI_SDI};
    end
  end

  always_ff @(negedge SPI_SCLK or posedge link_rst) begin
    if (link_rst) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  // Falling edge: hand a full word to the system side
  // Kept over select-high so the system clock can read it later
  always_comb begin
    h_d = h_q;
    if (f_q.cnt == (`FRAME_BITS - 5'd1)) begin           // Sixteenth bit
      h_d.word = {f_q.sh[14:0], SPI_SDI};
      h_d.tog  = ~h_q.tog;
      h_d.ovr  = 1'b0;
    end else if (f_q.cnt >= `FRAME_BITS) begin           // Too long
      h_d.ovr  = 1'b1;
    end
  end

  always_ff @(negedge SPI_SCLK or posedge RESET) begin
    if (RESET) begin
      h_q <= '0;
    end else begin
      h_q <= h_d;
    end
  end

  // Rising edge: shift out the addressed image, top five bits zero
  // The images are frozen while select is low, so reading them
  // from this clock is safe for the whole frame
  always_comb begin
    resp_data = `STATUS_RESET;
    if ((f_q.addr >= `RA_WARN) && (f_q.addr <= `RA_HS)) begin
      resp_data = s_q.snap[3'(f_q.addr - `RA_WARN)];
    end
    resp_idx = 4'(`FRAME_BITS - 5'd1 - f_q.cnt);
    r_d.sdo = 1'b0;
    if ((f_q.cnt >= `ADDR_FALLS) && (f_q.cnt < `FRAME_BITS)) begin
      r_d.sdo = resp_data[resp_idx];
    end
  end

  always_ff @(posedge SPI_SCLK or posedge link_rst) begin
    if (link_rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // Data out drives only while selected
  assign SPI_SDO    = r_q.sdo;
  assign SPI_SDO_OE = ~SPI_CS_N;

  // System side: syncs, images, command apply, sleep defaults
  always_comb begin
    s_d = s_q;
    s_d.mon_s1 = mon_raw;
    s_d.mon_s2 = s_q.mon_s1;
    s_d.tog_s1 = h_q.tog;
    s_d.tog_s2 = s_q.tog_s1;
    s_d.cs_s1  = SPI_CS_N;
    s_d.cs_s2  = s_q.cs_s1;
    s_d.sleep_q = SLEEP_ACTIVE;
    s_d.wd = 1'b0;
    // Images follow the monitors and the drive strength register only between frames
    if (s_q.cs_s2) begin
      s_d.snap[0] = warn_full;
      s_d.snap[1] = oc_img;
      s_d.snap[2] = dev_img;
      s_d.snap[3] = gate_img;
      s_d.snap[4] = s_q.hs;
    end
    // A finished frame is seen once; status writes are dropped
    if (commit_any) begin
      s_d.tog_seen = s_q.tog_s2;
    end
    if (commit_wr) begin
      s_d.hs = h_q.word[`DATA_MSB:0];
    end
    if (commit_rd) begin
      s_d.wd = 1'b1;
    end
    // Sleep entry wins over a write in the same cycle
    if (sleep_entry) begin
      s_d.hs = `HS_DEFAULT;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      s_q <= '0;
      s_q.hs <= `HS_DEFAULT;
    end else begin
      s_q <= s_d;
    end
  end

  // Drive strength fields out to the gate drivers
  assign HS_PEAK_DRIVE_TIME     = s_q.hs[`HS_TIME_MSB:`HS_TIME_LSB];
  assign HS_PEAK_SINK_CURRENT   = s_q.hs[`HS_SINK_MSB:`HS_SINK_LSB];
  assign HS_PEAK_SOURCE_CURRENT = s_q.hs[`HS_SRC_MSB:`HS_SRC_LSB];
  assign WD_SERVICE             = s_q.wd;

  // Checks on the system side
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  sleep_default_a: assert property (
    sleep_entry |=> (s_q.hs == `HS_DEFAULT))
    else $error("drive strength not default after sleep entry");

  hs_write_a: assert property (
    (commit_wr && !sleep_entry) |=> (s_q.hs == $past(h_q.word[10:0])))
    else $error("drive strength write not applied");

  hs_hold_a: assert property (
    (!commit_wr && !sleep_entry) |=> $stable(s_q.hs))
    else $error("drive strength changed without write or sleep");

  fault_or_a: assert property (
    s_q.cs_s2 |=> (s_q.snap[0][`WARN_FAULT_BIT] == $past(any_fault)))
    else $error("fault bit differs from fault OR");

  drain_or_a: assert property (
    s_q.cs_s2 |=> (s_q.snap[0][`WARN_DRAIN_BIT] == $past(|s_q.mon_s2[23:18])))
    else $error("drain OR bit wrong");

  reserved_bits_zero_a: assert property (
    (s_q.snap[1][4:3] == 2'h0) && (s_q.snap[3][4:0] == 5'h00) &&
    (s_q.snap[2][7] == 1'b0) && (s_q.snap[2][3] == 1'b0) &&
    (s_q.snap[0][9] == 1'b0))
    else $error("reserved status bit set");

  wd_pulse_a: assert property (
    commit_rd |=> WD_SERVICE ##1 !WD_SERVICE)
    else $error("watchdog service pulse wrong");

  snap_freeze_a: assert property (
    (!s_q.cs_s2 && !$past(s_q.cs_s2)) |-> $stable(s_q.snap))
    else $error("readback images moved during frame");

  // Each status image follows its own monitor bits between frames
  oc_image_a: assert property (
    s_q.cs_s2 |=> (s_q.snap[1] == $past(oc_img)))
    else $error("overcurrent image wrong");

  dev_image_a: assert property (
    s_q.cs_s2 |=> (s_q.snap[2] == $past(dev_img)))
    else $error("device fault image wrong");

  gate_image_a: assert property (
    s_q.cs_s2 |=> (s_q.snap[3] == $past(gate_img)))
    else $error("gate fault image wrong");

  // Temperature flags sit at bits 8 and 3..1 of the warning word
  temp_flags_a: assert property (
    s_q.cs_s2 |=> (s_q.snap[0][8] == $past(s_q.mon_s2[31])) &&
    (s_q.snap[0][3:1] == $past(s_q.mon_s2[27:25])))
    else $error("temperature flags misplaced");

  // Supply, pump and overtemperature warnings at bits 7, 6, 4, 0
  warn_bits_a: assert property (
    s_q.cs_s2 |=> (s_q.snap[0][7:6] == $past(s_q.mon_s2[30:29])) &&
    (s_q.snap[0][4] == $past(s_q.mon_s2[28])) &&
    (s_q.snap[0][0] == $past(s_q.mon_s2[24])))
    else $error("warning bits misplaced");

  // A write aimed at a status word must leave the control word alone
  status_ro_a: assert property (
    (commit_ok && !h_q.word[`RW_BIT] && !sleep_entry &&
     (h_q.word[`ADDR_MSB:`ADDR_LSB] != `RA_HS)) |=> $stable(s_q.hs))
    else $error("status write changed control word");

  // Readback image of the control word tracks the register
  hs_image_a: assert property (
    s_q.cs_s2 |=> (s_q.snap[4] == $past(s_q.hs)))
    else $error("control readback image stale");

  hs_fields_a: assert property (
    $rose(s_q.sleep_q) |-> (HS_PEAK_DRIVE_TIME == 2'h3) &&
    (HS_PEAK_SINK_CURRENT == 4'h4) && (HS_PEAK_SOURCE_CURRENT == 4'h4))
    else $error("drive fields not at default after sleep");

endmodule // gdrv_regs

// ===== pkg/gdrv_params.svh
`ifndef GDRV_PARAMS_SVH
`define GDRV_PARAMS_SVH

// Register addresses carried in frame bits 14:11
`define RA_WARN      4'h1
`define RA_OC        4'h2
`define RA_DEV       4'h3
`define RA_GATE      4'h4
`define RA_HS        4'h5

// Frame layout
`define FRAME_BITS   5'd16
`define FRAME_OVER   5'd17
`define RW_BIT       15
`define ADDR_MSB     14
`define ADDR_LSB     11
`define DATA_MSB     10
`define ADDR_FALLS   5'd5

// Warning word fields
`define WARN_FAULT_BIT 10
`define WARN_DRAIN_BIT 5

// Drive strength fields
`define HS_TIME_MSB  9
`define HS_TIME_LSB  8
`define HS_SINK_MSB  7
`define HS_SINK_LSB  4
`define HS_SRC_MSB   3
`define HS_SRC_LSB   0

// Reset values
`define HS_DEFAULT   11'h344
`define STATUS_RESET 11'h000

`endif

// ===== pkg/gdrv_pkg.sv
package gdrv_pkg;

  // Link side, falling edge: frame progress
  typedef struct packed {
    logic [4:0]  cnt;   // Falling edges seen, saturates
    logic [15:0] sh;    // Incoming shift register
    logic [3:0]  addr;  // Address caught after five bits
  } fall_state_t;

  // Link side, falling edge: finished word for the system side
  typedef struct packed {
    logic [15:0] word;  // Last full command word
    logic        tog;   // Flips once per full word
    logic        ovr;   // Frame ran past sixteen bits
  } hold_state_t;

  // Link side, rising edge: serial output
  typedef struct packed {
    logic sdo;          // Response bit on the line
  } rise_state_t;

  // System clock side
  typedef struct packed {
    logic [31:0]      mon_s1;   // Monitor sync, stage one
    logic [31:0]      mon_s2;   // Monitor sync, stage two
    logic             tog_s1;   // Word toggle sync, stage one
    logic             tog_s2;   // Word toggle sync, stage two
    logic             tog_seen; // Last toggle acted on
    logic             cs_s1;    // Select sync, stage one
    logic             cs_s2;    // Select sync, stage two
    logic             sleep_q;  // Sleep level, last cycle
    logic [10:0]      hs;       // Drive strength register
    logic [4:0][10:0] snap;     // Frozen images for readback
    logic             wd;       // Watchdog service pulse
  } sys_state_t;

endpackage

// ===== verif/gate_driver_status_control_regs_test.sv
`timescale 1ns/1ps
`include "gdrv_params.svh"
module gate_driver_status_control_regs_test;
  logic        CLK_SYS;      // System clock
  logic        RESET;        // Power-up reset
  logic        SLEEP_ACTIVE; // Sleep level
  logic [31:0] mon;          // All monitor levels in one vector
  wire         sclk;         // Link clock
  wire         cs_n;         // Link select
  wire         sdi;          // Link command data
  wire         sdo;          // Link response data
  wire         sdo_oe;       // Link response enable
  wire  [1:0]  t_code;       // Drive time field
  wire  [3:0]  sink_code;    // Sink current field
  wire  [3:0]  src_code;     // Source current field
  wire         wd_pulse;     // Watchdog service
  wire  [10:0] hs_pins = {1'b0, t_code, sink_code, src_code}; // Fields as one word
  int          bad_count = 0;   // Mismatches
  int          comparisons = 0; // Checks made
  int          wd_cnt = 0;      // Watchdog pulses seen
  logic [10:0] hs_vals [4] = '{11'h000, 11'h3ff, 11'h2b6, 11'h1c9}; // Write patterns

  spi_master_model m (.SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe));

  gdrv_regs DUT (
    .CLK_SYS(CLK_SYS), .RESET(RESET), .SPI_SCLK(sclk), .SPI_CS_N(cs_n), .SPI_SDI(sdi),
    .SPI_SDO(sdo), .SPI_SDO_OE(sdo_oe), .SLEEP_ACTIVE(SLEEP_ACTIVE),
    .TEMP_105_FLAG(mon[0]), .TEMP_125_FLAG(mon[1]), .TEMP_135_FLAG(mon[2]),
    .TEMP_175_FLAG(mon[3]), .MAIN_SUPPLY_LOW_WARN(mon[4]), .MAIN_SUPPLY_HIGH_WARN(mon[5]),
    .PUMP_LOW_WARN(mon[6]), .OVERHEAT_WARNING(mon[7]), .DRAIN_OC(mon[13:8]),
    .SENSE_OC(mon[16:14]), .SUPPLY_FAULTS(mon[19:17]), .REG_FAULTS(mon[22:20]),
    .PUMP_FAULTS(mon[25:23]), .GATE_FAULT(mon[31:26]), .HS_PEAK_DRIVE_TIME(t_code),
    .HS_PEAK_SINK_CURRENT(sink_code), .HS_PEAK_SOURCE_CURRENT(src_code),
    .WD_SERVICE(wd_pulse)
  );

  // Free-running system clock
  initial begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end

  // Count service pulses; a pulse stands one cycle
  always @(posedge CLK_SYS) if (wd_pulse === 1'b1) wd_cnt++;

  // Expected status word from the monitor levels
  function automatic logic [10:0] exp_status(logic [3:0] a, logic [31:0] v);
    logic [10:0] oc; // Overcurrent word
    logic [10:0] dv; // Device word
    logic [10:0] gt; // Gate word
    oc = {v[13:8], 2'b00, v[16:14]};
    dv = {v[19:17], 1'b0, v[22:20], 1'b0, v[25:23]};
    gt = {v[31:26], 5'h00};
    case (a)
      `RA_WARN: return {|{oc, dv, gt}, 1'b0, v[3], v[4], v[5], |v[13:8], v[6], v[0], v[1],
                        v[2], v[7]};
      `RA_OC:   return oc;
      `RA_DEV:  return dv;
      `RA_GATE: return gt;
      default:  return 11'h000;
    endcase
  endfunction

  task automatic tally_and_finish();
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(string what, logic [10:0] exp, logic [10:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One frame; n other than sixteen makes a broken frame
  task automatic xfer(int n, logic rw, logic [3:0] a, logic [10:0] d, output logic [10:0] r);
    logic [15:0] resp; // Whole response word
    m.frame(n, {rw, a, d}, resp);
    r = resp[10:0];
  endtask

  task automatic rd_chk(string what, logic [3:0] a, logic [10:0] exp);
    logic [10:0] r; // Read data
    xfer(16, 1'b1, a, 11'h000, r);
    chk(what, exp, r);
  endtask

  // Hang guard, twice the expected run of about half a millisecond
  initial begin
    #1000000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    logic [10:0] r;    // Response data
    logic [10:0] prev; // Register value before a write
    int          w0;   // Pulse count before a read
    RESET = 1'b1;
    SLEEP_ACTIVE = 1'b0;
    mon = 32'h0000_0000;
    repeat (3) @(posedge CLK_SYS);
    RESET <= 1'b0;
    repeat (6) @(posedge CLK_SYS);
    chk("hs_pins", `HS_DEFAULT, hs_pins);
    for (int a = 1; a <= 4; a++) rd_chk("status_reset", 4'(a), `STATUS_RESET);
    // Each monitor alone, then all together
    for (int i = 0; i <= 32; i++) begin
      @(posedge CLK_SYS) mon <= (i == 32) ? 32'hffff_ffff : 32'h1 << i;
      repeat (6) @(posedge CLK_SYS);
      for (int a = 1; a <= 4; a++) begin
        w0 = wd_cnt;
        rd_chk("status", 4'(a), exp_status(4'(a), mon));
        chk("wd_service", 11'(w0 + 1), 11'(wd_cnt));
      end
    end
    // Status words ignore writes
    @(posedge CLK_SYS) mon <= 32'h0000_0000;
    repeat (6) @(posedge CLK_SYS);
    for (int a = 1; a <= 4; a++) begin
      xfer(16, 1'b0, 4'(a), 11'h7ff, r);
      rd_chk("status_ro", 4'(a), `STATUS_RESET);
    end
    // Control register write, readback and pins
    prev = `HS_DEFAULT;
    foreach (hs_vals[k]) begin
      xfer(16, 1'b0, `RA_HS, hs_vals[k], r);
      chk("hs_wr_resp", prev, r);
      chk("hs_pins", hs_vals[k], hs_pins);
      w0 = wd_cnt;
      rd_chk("hs_reg", `RA_HS, hs_vals[k]);
      rd_chk("hs_keep", `RA_HS, hs_vals[k]);
      chk("wd_quiet", 11'(w0), 11'(wd_cnt));
      prev = hs_vals[k];
    end
    // Sleep entry restores the default
    @(posedge CLK_SYS) SLEEP_ACTIVE <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    SLEEP_ACTIVE <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    chk("hs_sleep", `HS_DEFAULT, hs_pins);
    rd_chk("hs_sleep_reg", `RA_HS, `HS_DEFAULT);
    // Short and long frames are dropped
    xfer(15, 1'b0, `RA_HS, 11'h155, r);
    xfer(17, 1'b0, `RA_HS, 11'h155, r);
    rd_chk("hs_bad_frame", `RA_HS, `HS_DEFAULT);
    // Unmapped address reads as zero and ignores writes
    xfer(16, 1'b0, 4'h9, 11'h7ff, r);
    rd_chk("unmapped", 4'h9, 11'h000);
    // Second power-up reset in mid-run
    xfer(16, 1'b0, `RA_HS, 11'h0b6, r);
    @(posedge CLK_SYS) RESET <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    RESET <= 1'b0;
    repeat (6) @(posedge CLK_SYS);
    chk("hs_reset", `HS_DEFAULT, hs_pins);
    rd_chk("hs_reset_reg", `RA_HS, `HS_DEFAULT);
    tally_and_finish();
  end
endmodule // gate_driver_status_control_regs_test

// ===== verif/spi_master_model.sv
`timescale 1ns/1ps
module spi_master_model (
  output logic      SCLK,   // Serial clock, still outside frames
  output logic      CS_N,   // Frame select, low active
  output logic      SDI,    // Command bits to the device
  input  wire logic SDO,    // Response bit from the device
  input  wire logic SDO_OE  // Response drive enable
);
  logic sdo_line; // Resolved data line as the master sees it

  // Released line shows the inverse of its last level, so a stale copy cannot pass
  always @(SDO or SDO_OE) sdo_line = SDO_OE ? SDO : ~sdo_line;

  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    SDI  = 1'b0;
  end

  // One frame of n bits, MSB first; bits beyond sixteen are zeros
  task automatic frame(input int n, input logic [15:0] w, output logic [15:0] r);
    logic [16:0] sh; // Outgoing bits
    sh = {w, 1'b0};
    r = 16'h0000;
    #3 CS_N <= 1'b0; // Select moves only while clock is low
    #200;
    for (int i = 0; i < n; i++) begin
      SCLK <= 1'b1; // Data launched on rising edge
      SDI <= sh[16];
      sh = sh << 1;
      #62.5 SCLK <= 1'b0;
      r = {r[14:0], sdo_line}; // Response captured at falling edge
      #62.5;
    end
    #100 CS_N <= 1'b1;
    SDI <= ~SDI; // Unselected input keeps moving
    #600; // Gap well over the minimum between frames
  endtask
endmodule // spi_master_model
